// File: logic/av_abort_vote.sv
// av_abort_vote: automatic abort decision with majority voted channels.
// assumes sensor and crew discretes are synchronous to pclk; apb master
// drives a 32-bit word interface.
// How it works
// - three channels, majority vote forms abort
// - status shows no abort active before release
// - liftoff arms automatic abort, none before
// - late abort cuts engines and aborts
// - early abort only starts abort sequence
// - engine cutoff locked out before set time
// - crew inhibit blocks whole automatic abort
// - range arming lights request, cuts thrust
// - two of three gyros in plane abort
// - one crew switch disables all planes
// - sequencer disables roll or all planes
// - overrate limits fixed in hardware only
// - two or more engines out aborts
// - sequencer disables engine-out vote
// - crew switch disables engine-out vote
// - engine lost when two sensors agree
// - crew shutdown without abort sequence
// - shutdown driven on two separate paths
// - crew starts second and third staging
// - no single fault raises an abort
//
// Added by the designer: the APB slave port and the address map.
module av_abort_vote
    import av_pkg::*;
#(
    parameter int NUM_ENG     = 5,          // monitored first-stage engines
    parameter int TICK_CYCLES = AV_TICK_CYC // cycles per flight ms
) (
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    // apb slave
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [7:0]             paddr,
    input  wire logic [31:0]            pwdata,
    output logic                        pready,
    output logic [31:0]                 prdata,
    output logic                        pslverr,
    // sensors and commands
    input  wire av_rate_t               rate_over,
    input  wire logic [2*NUM_ENG-1:0]   thrust_lost,
    input  wire av_disable_t            disables,
    input  wire logic                   liftoff,
    input  wire logic                   abort_inhibit,
    input  wire logic                   range_arm,
    input  wire logic                   manual_cut,
    input  wire logic                   stage2_req,
    input  wire logic                   stage3_req,
    // outputs toward crew vehicle and stages
    output logic                        no_abort_ok,
    output logic                        abort_seq,
    output logic                        abort_req_ind,
    output logic                        shut_a,
    output logic                        shut_b,
    output logic                        stage2_cmd,
    output logic                        stage3_cmd
);

    // ==========================================================
    // helpers

    // two of three majority
    function automatic logic maj3(input logic [2:0] v);
        maj3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
    endfunction

    // true when two or more engines have lost thrust
    function automatic logic two_out(input logic [2*NUM_ENG-1:0] s);
        int n;
        n = 0;
        for (int e = 0; e < NUM_ENG; e++) begin
            if (s[2*e] & s[2*e+1]) begin // both sensors agree
                n++;
            end
        end
        two_out = (n >= 2);
    endfunction

    // ==========================================================
    // state

    av_phase_t   phase;        // flight phase
    logic [15:0] preset_ms;    // abort-to-cutoff preset, software set
    logic [15:0] lockout_ms;   // cutoff lockout, software set
    logic [15:0] flight_ms;    // saturating ms since liftoff
    logic [31:0] tick_cnt;     // divider for the ms enable
    logic        tick;         // one-cycle ms enable
    logic [2:0]  chan_abort;   // registered channel decisions
    logic        vote;         // majority of channels
    logic        cut_ok;       // preset and lockout both elapsed
    logic        next_shut;    // shutdown cause this cycle

    // overrate thresholds are trimmed inside the gyro package; only the
    // exceeded discretes arrive here, so no register can move them

    // ==========================================================
    // millisecond divider, one clock domain only

    // tick pulses once every TICK_CYCLES cycles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt <= 32'h0000_0000;
            tick     <= 1'b0;
        end else if (tick_cnt == 32'(TICK_CYCLES - 1)) begin
            tick_cnt <= 32'h0000_0000;
            tick     <= 1'b1;
        end else begin
            tick_cnt <= tick_cnt + 32'h0000_0001;
            tick     <= 1'b0;
        end
    end

    // ==========================================================
    // flight phase

    // liftoff arms; abort holds until reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase <= AV_PRE;
        end else begin
            case (phase)
                AV_PRE: begin
                    if (liftoff) begin
                        phase <= AV_ARMED;
                    end
                end
                AV_ARMED: begin
                    if (vote) begin
                        phase <= AV_ABORTED;
                    end
                end
                AV_ABORTED: begin
                    phase <= AV_ABORTED;
                end
                default: begin
                    phase <= AV_PRE;
                end
            endcase
        end
    end

    // flight timer runs from liftoff, saturates rather than wraps
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flight_ms <= 16'h0000;
        end else if (phase != AV_PRE && tick && flight_ms != 16'hFFFF) begin
            flight_ms <= flight_ms + 16'h0001;
        end
    end

    // ==========================================================
    // three voting channels

    // each channel has its own copy of the vote and its own flop, so a
    // stuck flop in one channel is outvoted by the other two
    for (genvar g = 0; g < 3; g++) begin : g_chan
        logic rate_v; // overrate vote in this channel
        logic eng_v;  // engine-out vote in this channel
        always_comb begin
            rate_v = 1'b0;
            if (!disables.rate_off_man && !disables.pyr_off_seq) begin
                rate_v = maj3(rate_over.pitch)
                       | maj3(rate_over.yaw)
                       | (maj3(rate_over.roll) & !disables.roll_off_seq);
            end
            eng_v = two_out(thrust_lost)
                  & !disables.eng_off_seq
                  & !disables.eng_off_man;
        end
        // gated or of both votes, registered once per clock
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                chan_abort[g] <= 1'b0;
            end else begin
                chan_abort[g] <= (phase != AV_PRE)
                               & !abort_inhibit
                               & (rate_v | eng_v);
            end
        end
    end

    assign vote   = maj3(chan_abort);
    assign cut_ok = (flight_ms >= preset_ms) && (flight_ms >= lockout_ms);

    // ==========================================================
    // abort and shutdown outputs

    // abort sequence latches on the vote; manual cut never touches it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            abort_seq <= 1'b0;
        end else if (vote) begin
            abort_seq <= 1'b1;
        end
    end

    // early abort leaves cutoff to range safety; the lockout covers the
    // same window so a mistuned preset still cannot cut early
    // only the vote that starts the abort may cut; a vote still held after an
    // early abort must not cut once the timers run out
    always_comb begin
        next_shut = range_arm
                  | manual_cut
                  | (vote & !abort_seq & cut_ok);
    end

    // two independently registered shutdown paths, sticky once set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shut_a <= 1'b0;
            shut_b <= 1'b0;
        end else begin
            shut_a <= shut_a | next_shut;
            shut_b <= shut_b | next_shut;
        end
    end

    // range arming lights the request indicator and holds it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            abort_req_ind <= 1'b0;
        end else if (range_arm) begin
            abort_req_ind <= 1'b1;
        end
    end

    // ready status: no channel voting and no abort latched
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            no_abort_ok <= 1'b0;
        end else begin
            no_abort_ok <= (chan_abort == 3'b000) && !abort_seq && !vote;
        end
    end

    // crew staging commands, latched so a bounce cannot drop them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage2_cmd <= 1'b0;
            stage3_cmd <= 1'b0;
        end else begin
            stage2_cmd <= stage2_cmd | stage2_req;
            stage3_cmd <= stage3_cmd | stage3_req;
        end
    end

    // ==========================================================
    // apb slave, no wait state: answer in the first access cycle

    // registers are written only at the completing access edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            preset_ms  <= AV_PRESET_RST;
            lockout_ms <= AV_LOCKOUT_RST;
        end else if (psel && penable && pready && pwrite) begin
            case (paddr)
                AV_OFF_PRESET:  preset_ms  <= pwdata[15:0];
                AV_OFF_LOCKOUT: lockout_ms <= pwdata[15:0];
                default: begin
                end
            endcase
        end
    end

    // answer flops load in the setup cycle and drop after the access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            pready  <= 1'b1;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            case (paddr)
                AV_OFF_PRESET:  prdata[15:0] <= preset_ms;
                AV_OFF_LOCKOUT: prdata[15:0] <= lockout_ms;
                AV_OFF_STATUS: begin
                    prdata[AV_ST_ARMED]          <= (phase != AV_PRE);
                    prdata[AV_ST_ABORT]          <= abort_seq;
                    prdata[AV_ST_SHUT]           <= shut_a;
                    prdata[AV_ST_RANGE]          <= abort_req_ind;
                    prdata[AV_ST_CHAN+2:AV_ST_CHAN] <= chan_abort;
                end
                AV_OFF_FLIGHT:  prdata[15:0] <= flight_ms;
                default:        pslverr <= 1'b1; // unmapped
            endcase
            if (pwrite && (paddr == AV_OFF_STATUS || paddr == AV_OFF_FLIGHT)) begin
                pslverr <= 1'b1; // read-only word
            end
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // ==========================================================
    // checks

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_pad_quiet: assert property ((phase == AV_PRE) |-> ##1 (chan_abort == 3'b000))
        else $error("channel voted before liftoff");

    a_vote_major: assert property (($countones(chan_abort) >= 2) |=> abort_seq)
        else $error("majority of channels did not start abort");

    a_single_chan: assert property (($countones(chan_abort) == 1 && !$past(abort_seq)
                                      && !abort_seq) |=> !abort_seq)
        else $error("single channel raised abort");

    a_inhibit_all: assert property (abort_inhibit |=> (chan_abort == 3'b000))
        else $error("inhibit did not block automatic abort");

    a_late_cut: assert property ((vote && cut_ok && !abort_seq) |=> (shut_a && shut_b))
        else $error("late abort did not cut engines");

    a_early_keep: assert property ((!shut_a && vote && (flight_ms < lockout_ms
                                    || flight_ms < preset_ms) && !range_arm
                                    && !manual_cut) |=> !shut_a)
        else $error("engines cut inside preset or lockout window");

    a_range_cut: assert property (range_arm |=> (abort_req_ind && shut_a))
        else $error("range arming missed request or cutoff");

    a_paths_same: assert property (shut_a == shut_b)
        else $error("shutdown paths disagree");

    a_manual_cut: assert property ((manual_cut && !abort_seq && !vote)
                                   |=> (shut_a && !abort_seq))
        else $error("manual cut failed or started abort");

    a_ready_flag: assert property (abort_seq |=> !no_abort_ok)
        else $error("ready status shown with abort latched");

    a_apb_wait: assert property ((psel && !penable) |=> (pready ##1 !pready)) // bus timing
        else $error("apb answer not one cycle");

    a_late_hold: assert property (
        (abort_seq && !shut_a && !range_arm && !manual_cut) |=> !shut_a)
        else $error("held early abort cut engines later");

    a_rate_off: assert property (
        (disables.rate_off_man && !two_out(thrust_lost)) |=> (chan_abort == 3'b000))
        else $error("crew switch did not disable overrate vote");

    a_pyr_off: assert property (
        (disables.pyr_off_seq && !two_out(thrust_lost)) |=> (chan_abort == 3'b000))
        else $error("sequencer did not disable all planes");

    a_roll_off: assert property (
        (disables.roll_off_seq && !maj3(rate_over.pitch) && !maj3(rate_over.yaw)
         && !two_out(thrust_lost)) |=> (chan_abort == 3'b000))
        else $error("sequencer did not disable roll plane");

    a_eng_off: assert property (
        ((disables.eng_off_seq || disables.eng_off_man) && (rate_over == '0))
        |=> (chan_abort == 3'b000))
        else $error("engine-out vote not disabled");

    a_gyro_vote: assert property (
        ((phase != AV_PRE) && !abort_inhibit && !disables.rate_off_man
         && !disables.pyr_off_seq && maj3(rate_over.pitch)) |=> (chan_abort == 3'b111))
        else $error("two of three gyros did not vote");

    a_engine_vote: assert property (
        ((phase != AV_PRE) && !abort_inhibit && !disables.eng_off_seq
         && !disables.eng_off_man && (&thrust_lost[3:0])) |=> (chan_abort == 3'b111))
        else $error("two engines out did not vote");

    a_one_sensor: assert property (
        ((rate_over == '0) && ((thrust_lost & (thrust_lost >> 1) & {NUM_ENG{2'b01}}) == '0))
        |=> (chan_abort == 3'b000))
        else $error("engine declared lost on one sensor");

    a_stage2_cmd: assert property (
        stage2_req |=> stage2_cmd)
        else $error("second stage staging not commanded");

    a_stage3_cmd: assert property (
        stage3_req |=> stage3_cmd)
        else $error("third stage staging not commanded");

endmodule

// File: logic/av_pkg.sv
// av_pkg: shared constants and carrier types for the abort vote block.
// assumes a single 20 MHz clock; registers sit on a 32-bit apb slave.
package av_pkg;
    // ==========================================================
    // timing
    localparam int AV_CLK_NS  = 50;      // pclk period in ns
    localparam int AV_TICK_NS = 1000000; // flight timer resolution, 1 ms
    localparam int AV_TICK_CYC = AV_TICK_NS / AV_CLK_NS; // cycles per ms

    // ==========================================================
    // register byte offsets
    localparam logic [7:0] AV_OFF_PRESET  = 8'h00; // shutdown preset, ms
    localparam logic [7:0] AV_OFF_LOCKOUT = 8'h04; // shutdown lockout, ms
    localparam logic [7:0] AV_OFF_STATUS  = 8'h08; // block state, read only
    localparam logic [7:0] AV_OFF_FLIGHT  = 8'h0C; // ms since liftoff

    // reset values
    localparam logic [15:0] AV_PRESET_RST  = 16'h2710; // 10 s
    localparam logic [15:0] AV_LOCKOUT_RST = 16'h61A8; // 25 s

    // status field positions
    localparam int AV_ST_ARMED = 0;
    localparam int AV_ST_ABORT = 1;
    localparam int AV_ST_SHUT  = 2;
    localparam int AV_ST_RANGE = 3;
    localparam int AV_ST_CHAN  = 4; // three channel votes, bits 6:4

    // ==========================================================
    // flight phase
    typedef enum logic [1:0] {
        AV_PRE     = 2'b00, // on the pad, automatic abort disarmed
        AV_ARMED   = 2'b01, // liftoff seen, votes live
        AV_ABORTED = 2'b10  // abort sequence commanded, held
    } av_phase_t;

    // overrate discretes, three gyros per plane
    typedef struct packed {
        logic [2:0] pitch;
        logic [2:0] yaw;
        logic [2:0] roll;
    } av_rate_t;

    // disable switches from crew and sequencer
    typedef struct packed {
        logic rate_off_man; // one switch, all three planes
        logic roll_off_seq; // sequencer, roll plane only
        logic pyr_off_seq;  // sequencer, pitch yaw and roll
        logic eng_off_seq;  // sequencer, engine-out vote
        logic eng_off_man;  // crew, engine-out vote
    } av_disable_t;
endpackage

// File: tb/av_flight_side.sv
// av_flight_side: sensors, sequencer and crew panel facing the abort block.
// assumes the bench calls drive() from its main thread; one clock, pclk.
module av_flight_side
    import av_pkg::*;
(
    input  wire logic  pclk,
    output av_rate_t    rate_over,
    output logic [9:0]  thrust_lost,
    output av_disable_t disables,
    output logic        liftoff,
    output logic        abort_inhibit,
    output logic        range_arm,
    output logic        manual_cut,
    output logic        stage2_req,
    output logic        stage3_req
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // quiet pad state at time zero
    initial begin
        rate_over     = '0;
        thrust_lost   = '0;
        disables      = '0;
        liftoff       = 1'b0;
        abort_inhibit = 1'b0;
        {range_arm, manual_cut, stage2_req, stage3_req} = 4'h0;
    end
    // ==========================================================
    // all discretes change together just after an edge
    task automatic drive(input logic [8:0] r, input logic [9:0] t, input logic [4:0] d,
                         input logic inh, input logic lo, input logic [3:0] c);
        @(posedge pclk);
        rate_over     <= av_rate_t'(r);
        thrust_lost   <= t;
        disables      <= av_disable_t'(d);
        abort_inhibit <= inh;
        liftoff       <= lo;
        {range_arm, manual_cut, stage2_req, stage3_req} <= c;
    endtask
endmodule

// File: tb/tb_av_abort_vote.sv
// tb_av_abort_vote: table driven bench for the abort vote block.
// assumes a short flight tick so the preset and lockout are reachable.
module tb_av_abort_vote
    import av_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // shortened timing
    localparam int TICK = 4;   // cycles per flight ms
    localparam int PRE  = 10;  // preset, ms
    localparam int LOCK = 30;  // lockout, ms
    logic pclk, presetn, psel, penable, pwrite, snap;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic pready, pslverr;
    av_rate_t rate_over;
    logic [9:0] thrust_lost;
    av_disable_t disables;
    logic liftoff, abort_inhibit, range_arm, manual_cut, stage2_req, stage3_req;
    logic no_abort_ok, abort_seq, abort_req_ind, shut_a, shut_b, stage2_cmd, stage3_cmd;
    logic [33:0] rd_q[$];      // {is_read, err, data}
    logic [13:0] out_q[$];     // {mask, value}
    logic [33:0] e;
    logic [13:0] o;
    logic [44:0] tbl[21];
    int n_fail, samples_checked, i, seed;
    logic [31:0] r;
    wire [6:0] outs = {no_abort_ok, abort_seq, abort_req_ind, shut_a, shut_b,
                       stage2_cmd, stage3_cmd};
    av_abort_vote #(.NUM_ENG(5), .TICK_CYCLES(TICK)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .rate_over(rate_over), .thrust_lost(thrust_lost), .disables(disables),
        .liftoff(liftoff), .abort_inhibit(abort_inhibit), .range_arm(range_arm),
        .manual_cut(manual_cut), .stage2_req(stage2_req), .stage3_req(stage3_req),
        .no_abort_ok(no_abort_ok), .abort_seq(abort_seq), .abort_req_ind(abort_req_ind),
        .shut_a(shut_a), .shut_b(shut_b), .stage2_cmd(stage2_cmd), .stage3_cmd(stage3_cmd)
    );
    av_flight_side far (
        .pclk(pclk), .rate_over(rate_over), .thrust_lost(thrust_lost), .disables(disables),
        .liftoff(liftoff), .abort_inhibit(abort_inhibit), .range_arm(range_arm),
        .manual_cut(manual_cut), .stage2_req(stage2_req), .stage3_req(stage3_req)
    );
    // ==========================================================
    // clock and watchdog
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    initial begin
        #4ms;
        fail("watchdog");
        report_and_stop();
    end
    task automatic fail(input string m);
        n_fail++;
        $display("[ERR] %0t %s", $time, m);
    endtask
    task automatic report_and_stop();
        if (n_fail == 0 && samples_checked > 0 && rd_q.size() == 0 && out_q.size() == 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // ==========================================================
    // monitor: settled at the falling edge, oldest note first
    always @(negedge pclk) begin
        if (psel && penable && pready) begin
            e = rd_q.pop_front();
            samples_checked++;
            if (pslverr !== e[32] || (e[33] && prdata !== e[31:0])) fail("apb answer");
        end
        if (snap) begin
            o = out_q.pop_front();
            samples_checked++;
            if ((outs & o[13:7]) !== (o[6:0] & o[13:7])) fail("command outputs");
        end
    end
    // ==========================================================
    // apb master: setup, then access held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] ed, input logic ee);
        logic got;
        rd_q.push_back({!wr, ee, ed});
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        got = 1'b0;
        for (int k = 0; k < 20 && !got; k++) begin
            @(posedge pclk);
            got = pready; // value standing at this rising edge
        end
        {psel, penable} <= 2'b00;
        if (!got) begin
            fail("pready timeout");
            report_and_stop();
        end
    endtask
    task automatic expect_out(input logic [6:0] v, input logic [6:0] m);
        out_q.push_back({m, v});
        snap <= 1'b1;
        @(posedge pclk);
        snap <= 1'b0;
        @(posedge pclk);
    endtask
    // reset, then load the short preset and lockout; upper bits must read 0
    task automatic restart();
        far.drive(9'h0, 10'h0, 5'h0, 1'b0, 1'b0, 4'h0);
        presetn <= 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        r = $random(seed);
        apb(1'b1, AV_OFF_PRESET, {r[31:16], 16'(PRE)}, 32'h0, 1'b0);
        apb(1'b1, AV_OFF_LOCKOUT, {r[15:0], 16'(LOCK)}, 32'h0, 1'b0);
        apb(1'b0, AV_OFF_PRESET, 32'h0, 32'(PRE), 1'b0);
    endtask
    // one flight: arm, wait for the phase, apply discretes, check at N+4 and on
    task automatic run_case(input logic [44:0] c);
        restart();
        if (c[15:14] != 2'd0) far.drive(9'h0, 10'h0, 5'h0, 1'b0, 1'b1, 4'h0);
        repeat (c[15:14] == 2'd1 ? 2 : c[15:14] == 2'd2 ? (PRE + 2) * TICK
                : (LOCK + 2) * TICK) @(posedge pclk);
        far.drive(c[44:36], c[35:26], c[25:21], c[20], c[15:14] != 2'd0, c[19:16]);
        repeat (4) @(posedge pclk);
        expect_out(c[13:7], c[6:0]);
    endtask
    function automatic logic maj(input logic [2:0] b);
        return (b[0] & b[1]) | (b[0] & b[2]) | (b[1] & b[2]);
    endfunction
    // ==========================================================
    // main sequence
    initial begin
        {presetn, psel, penable, pwrite, snap, paddr, pwdata} = '0;
        seed = 35411;
        // {rate, thrust, disables, inhibit, cmd, phase, value, mask}
        tbl[0]  = {9'h1C0, 10'h3FF, 5'h00, 1'b0, 4'h0, 2'd0, 7'h40, 7'h7F};
        tbl[1]  = {9'h111, 10'h000, 5'h00, 1'b0, 4'h0, 2'd1, 7'h40, 7'h7F};
        tbl[2]  = {9'h000, 10'h005, 5'h00, 1'b0, 4'h0, 2'd1, 7'h40, 7'h7F};
        tbl[3]  = {9'h000, 10'h003, 5'h00, 1'b0, 4'h0, 2'd1, 7'h40, 7'h7F};
        tbl[4]  = {9'h0C0, 10'h000, 5'h00, 1'b0, 4'h0, 2'd1, 7'h20, 7'h7F};
        tbl[5]  = {9'h028, 10'h000, 5'h00, 1'b0, 4'h0, 2'd1, 7'h20, 7'h7F};
        tbl[6]  = {9'h006, 10'h000, 5'h00, 1'b0, 4'h0, 2'd3, 7'h2C, 7'h7F};
        tbl[7]  = {9'h000, 10'h303, 5'h00, 1'b0, 4'h0, 2'd1, 7'h20, 7'h7F};
        tbl[8]  = {9'h1C0, 10'h000, 5'h00, 1'b1, 4'h0, 2'd1, 7'h40, 7'h7F};
        tbl[9]  = {9'h000, 10'h00F, 5'h00, 1'b1, 4'h0, 2'd3, 7'h40, 7'h7F};
        tbl[10] = {9'h1FF, 10'h000, 5'h10, 1'b0, 4'h0, 2'd1, 7'h40, 7'h7F};
        tbl[11] = {9'h003, 10'h000, 5'h08, 1'b0, 4'h0, 2'd1, 7'h40, 7'h7F};
        tbl[12] = {9'h0C0, 10'h000, 5'h08, 1'b0, 4'h0, 2'd1, 7'h20, 7'h7F};
        tbl[13] = {9'h018, 10'h000, 5'h04, 1'b0, 4'h0, 2'd1, 7'h40, 7'h7F};
        tbl[14] = {9'h000, 10'h00F, 5'h02, 1'b0, 4'h0, 2'd1, 7'h40, 7'h7F};
        tbl[15] = {9'h000, 10'h00F, 5'h01, 1'b0, 4'h0, 2'd1, 7'h40, 7'h7F};
        tbl[16] = {9'h000, 10'h00F, 5'h10, 1'b0, 4'h0, 2'd1, 7'h20, 7'h7F};
        tbl[17] = {9'h180, 10'h000, 5'h00, 1'b0, 4'h0, 2'd2, 7'h20, 7'h7F};
        tbl[18] = {9'h000, 10'h000, 5'h00, 1'b0, 4'h8, 2'd1, 7'h1C, 7'h1F};
        tbl[19] = {9'h000, 10'h000, 5'h00, 1'b0, 4'h4, 2'd0, 7'h0C, 7'h3F};
        tbl[20] = {9'h000, 10'h000, 5'h00, 1'b0, 4'h3, 2'd1, 7'h03, 7'h3F};
        // register reset values, read-only and unmapped places
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, AV_OFF_PRESET, 32'h0, {16'h0, AV_PRESET_RST}, 1'b0);
        apb(1'b0, AV_OFF_LOCKOUT, 32'h0, {16'h0, AV_LOCKOUT_RST}, 1'b0);
        apb(1'b0, AV_OFF_STATUS, 32'h0, 32'h0, 1'b0);
        apb(1'b1, AV_OFF_STATUS, 32'hFFFF_FFFF, 32'h0, 1'b1);
        apb(1'b0, 8'h10, 32'h0, 32'h0, 1'b1);
        apb(1'b1, AV_OFF_FLIGHT, 32'h1, 32'h0, 1'b1);
        expect_out(7'h40, 7'h7F);
        for (i = 0; i < 21; i++) begin
            run_case(tbl[i]);
            if (i == 0) apb(1'b0, AV_OFF_FLIGHT, 32'h0, 32'h0, 1'b0);
            if (i == 6) apb(1'b0, AV_OFF_STATUS, 32'h0, 32'h77, 1'b0);
        end
        // random gyro patterns against a two-of-three reference
        for (i = 0; i < 8; i++) begin
            r = $random(seed);
            run_case({r[8:0], 10'h0, 5'h0, 1'b0, 4'h0, 2'd1,
                      (maj(r[8:6]) | maj(r[5:3]) | maj(r[2:0])) ? 7'h20 : 7'h40,
                      7'h7F});
        end
        // early vote held past preset and lockout must never cut later
        restart();
        far.drive(9'h1C0, 10'h0, 5'h0, 1'b0, 1'b1, 4'h0);
        repeat ((LOCK + 4) * TICK) @(posedge pclk);
        expect_out(7'h20, 7'h7F);
        repeat (4) @(posedge pclk);
        report_and_stop();
    end
endmodule
